// file: hdl/qhb_pkg.sv
package qhb_pkg;
	// Bus style seen on the mode pin.
	localparam logic MODE_STROBE = 1'b1;
	localparam logic MODE_RW_LINE = 1'b0;
	// Register index of the modem control register within a channel.
	localparam logic [2:0] MODEM_CTRL_IDX = 3'h4;
	localparam int MODEM_CTRL_IRQ_EN_BIT = 3;
	// How the interrupt-select level is obtained.
	localparam logic [1:0] SEL_FROM_PIN = 2'h0;
	localparam logic [1:0] SEL_TIED_HIGH = 2'h1;
	localparam logic [1:0] SEL_TIED_LOW = 2'h2;
	localparam int NUM_CHAN = 4;
	// Layout of the synchronised pin vector.
	localparam int PIN_W = 19;
	localparam int PIN_MODE = 0;
	localparam int PIN_WR_N = 1;
	localparam int PIN_RD_N = 2;
	localparam int PIN_CS_LO = 3;
	localparam int PIN_ADDR_LO = 7;
	localparam int PIN_DATA_LO = 10;
	localparam int PIN_SEL = 18;
	// Strobes and selects rest high, so reset looks like an idle bus.
	localparam logic [18:0] PIN_RST_VAL = 19'h0007ff;
endpackage

// file: hdl/qhb_pin_sync.sv
`timescale 1ns/1ps
module qhb_pin_sync import qhb_pkg::*; #(
	parameter int WIDTH = PIN_W,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [WIDTH-1:0] i_pins,
	output logic [WIDTH-1:0] o_pins
);
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			logic s1_r;
			logic s2_r;
			logic s3_r;
			logic lvl_r;
			// A change is accepted only once two settled stages agree.
			always_ff @(posedge i_clk) begin
				if (i_rst) begin
					s1_r <= RST_VAL[g];
					s2_r <= RST_VAL[g];
					s3_r <= RST_VAL[g];
					lvl_r <= RST_VAL[g];
				end else begin
					s1_r <= i_pins[g];
					s2_r <= s1_r;
					s3_r <= s2_r;
					if (s2_r == s3_r) begin
						lvl_r <= s3_r;
					end
				end
			end
			assign o_pins[g] = lvl_r;
		end
	endgenerate
endmodule // qhb_pin_sync

// file: hdl/qhb_host_bus.sv
`timescale 1ns/1ps
module qhb_host_bus import qhb_pkg::*; #(
	parameter logic [1:0] SEL_SOURCE = SEL_FROM_PIN
) (
	input wire logic I_MCLK,
	input wire logic I_SYS_RST,
	input wire logic I_BUS_MODE,
	input wire logic I_WRITE_STROBE_N,
	input wire logic I_READ_STROBE_N,
	input wire logic I_CHAN_A_SELECT_N,
	input wire logic I_CHAN_B_SELECT_N,
	input wire logic I_CHAN_C_SELECT_N,
	input wire logic I_CHAN_D_SELECT_N,
	input wire logic [2:0] I_ADDR,
	input wire logic [7:0] I_DATA,
	input wire logic I_IRQ_DRIVE_OVERRIDE,
	input wire logic [3:0] I_CHAN_IRQ_PEND,
	input wire logic [7:0] I_REG_RDATA,
	output logic [7:0] O_DATA,
	output logic O_DATA_OE_N,
	output logic O_REG_RD,
	output logic O_REG_WR,
	output logic [1:0] O_REG_CHAN,
	output logic [2:0] O_REG_ADDR,
	output logic [7:0] O_REG_WDATA,
	output logic O_CHAN_A_IRQ_OUT,
	output logic O_CHAN_A_IRQ_OE_N,
	output logic O_CHAN_B_IRQ_OUT,
	output logic O_CHAN_B_IRQ_OE_N,
	output logic O_CHAN_C_IRQ_OUT,
	output logic O_CHAN_C_IRQ_OE_N,
	output logic O_CHAN_D_IRQ_OUT,
	output logic O_CHAN_D_IRQ_OE_N
);
	typedef enum logic [1:0] {ST_IDLE, ST_RD_WAIT, ST_RD_HOLD,
		ST_WR_HOLD} qhb_state_t;

	logic [PIN_W-1:0] pins_raw;
	logic [PIN_W-1:0] pins;
	logic mode;
	logic wr_n;
	logic rd_n;
	logic [3:0] cs_n;
	logic [2:0] addr;
	logic [7:0] data;
	logic sel_pin;
	logic sel;
	logic any_cs;
	logic [1:0] cs_chan;
	logic start_rd;
	logic start_wr;
	logic rd_done;
	logic wr_done;
	qhb_state_t state_r;
	logic [7:0] data_out_r;
	logic data_oe_n_r;
	logic reg_rd_r;
	logic reg_wr_r;
	logic [1:0] chan_r;
	logic [2:0] addr_r;
	logic [7:0] wdata_r;
	logic [3:0] irq_en_r;
	logic [3:0] irq_out_r;
	logic [3:0] irq_oe_n_r;

	// The pull-down lives in the pad, so an open pin arrives here as low.
	assign pins_raw = {I_IRQ_DRIVE_OVERRIDE, I_DATA, I_ADDR,
		I_CHAN_D_SELECT_N, I_CHAN_C_SELECT_N, I_CHAN_B_SELECT_N,
		I_CHAN_A_SELECT_N, I_READ_STROBE_N, I_WRITE_STROBE_N, I_BUS_MODE};

	qhb_pin_sync #(
		.WIDTH(PIN_W),
		.RST_VAL(PIN_RST_VAL)
	) u_sync (
		.i_clk(I_MCLK),
		.i_rst(I_SYS_RST),
		.i_pins(pins_raw),
		.o_pins(pins)
	);

	assign mode = pins[PIN_MODE];
	assign wr_n = pins[PIN_WR_N];
	assign rd_n = pins[PIN_RD_N];
	assign cs_n = pins[PIN_CS_LO +: 4];
	assign addr = pins[PIN_ADDR_LO +: 3];
	assign data = pins[PIN_DATA_LO +: 8];
	assign sel_pin = pins[PIN_SEL];

	// Fixed variants ignore the pin entirely.
	assign sel = (SEL_SOURCE == SEL_TIED_HIGH) ? 1'b1 :
		(SEL_SOURCE == SEL_TIED_LOW) ? 1'b0 : sel_pin;

	// Strobe mode: lowest active select wins if the host selects several.
	// Line mode: select A enables, B and C carry the channel, D is unused.
	always_comb begin
		if (mode == MODE_STROBE) begin
			any_cs = ~&cs_n;
			if (!cs_n[0]) begin
				cs_chan = 2'h0;
			end else if (!cs_n[1]) begin
				cs_chan = 2'h1;
			end else if (!cs_n[2]) begin
				cs_chan = 2'h2;
			end else begin
				cs_chan = 2'h3;
			end
		end else begin
			any_cs = !cs_n[0];
			cs_chan = {cs_n[2], cs_n[1]};
		end
	end

	always_comb begin
		if (mode == MODE_STROBE) begin
			start_rd = any_cs && !rd_n;
			start_wr = any_cs && !wr_n && rd_n;
			rd_done = rd_n || !any_cs;
			wr_done = wr_n;
		end else begin
			start_rd = any_cs && wr_n;
			start_wr = any_cs && !wr_n;
			rd_done = !any_cs;
			wr_done = !any_cs;
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (I_SYS_RST) begin
			state_r <= ST_IDLE;
			chan_r <= 2'h0;
			addr_r <= 3'h0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (start_rd || start_wr) begin
						chan_r <= cs_chan;
						addr_r <= addr;
						state_r <= start_rd ? ST_RD_WAIT : ST_WR_HOLD;
					end
				end
				ST_RD_WAIT: begin
					state_r <= ST_RD_HOLD;
				end
				ST_RD_HOLD: begin
					if (rd_done) begin
						state_r <= ST_IDLE;
					end
				end
				ST_WR_HOLD: begin
					if (wr_done) begin
						state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Channel cores see a one-cycle request carrying channel and register.
	always_ff @(posedge I_MCLK) begin
		if (I_SYS_RST) begin
			reg_rd_r <= 1'b0;
			reg_wr_r <= 1'b0;
			wdata_r <= 8'h00;
		end else begin
			reg_rd_r <= (state_r == ST_IDLE) && start_rd;
			reg_wr_r <= (state_r == ST_WR_HOLD) && wr_done;
			if ((state_r == ST_WR_HOLD) && wr_done) begin
				wdata_r <= data;
			end
		end
	end

	// Read data is captured one cycle after the request and held to the end.
	always_ff @(posedge I_MCLK) begin
		if (I_SYS_RST) begin
			data_out_r <= 8'h00;
			data_oe_n_r <= 1'b1;
		end else begin
			if (state_r == ST_RD_WAIT) begin
				data_out_r <= I_REG_RDATA;
				data_oe_n_r <= 1'b0;
			end else if ((state_r == ST_RD_HOLD) && rd_done) begin
				data_oe_n_r <= 1'b1;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CHAN; g++) begin : g_irq
			// A copy of the enable bit is snooped from writes to the channel.
			always_ff @(posedge I_MCLK) begin
				if (I_SYS_RST) begin
					irq_en_r[g] <= 1'b0;
				end else if ((state_r == ST_WR_HOLD) && wr_done &&
					(chan_r == 2'(g)) && (addr_r == MODEM_CTRL_IDX)) begin
					irq_en_r[g] <= data[MODEM_CTRL_IRQ_EN_BIT];
				end
			end
			always_ff @(posedge I_MCLK) begin
				if (I_SYS_RST) begin
					irq_out_r[g] <= 1'b0;
					irq_oe_n_r[g] <= 1'b1;
				end else if (mode == MODE_STROBE) begin
					irq_out_r[g] <= I_CHAN_IRQ_PEND[g];
					irq_oe_n_r[g] <= !(sel || irq_en_r[g]);
				end else if (g == 0) begin
					// Open drain: only ever pulls low, a pull-up gives high.
					irq_out_r[g] <= 1'b0;
					irq_oe_n_r[g] <= ~|I_CHAN_IRQ_PEND;
				end else begin
					irq_out_r[g] <= 1'b0;
					irq_oe_n_r[g] <= 1'b0;
				end
			end
		end
	endgenerate

	assign O_DATA = data_out_r;
	assign O_DATA_OE_N = data_oe_n_r;
	assign O_REG_RD = reg_rd_r;
	assign O_REG_WR = reg_wr_r;
	assign O_REG_CHAN = chan_r;
	assign O_REG_ADDR = addr_r;
	assign O_REG_WDATA = wdata_r;
	assign O_CHAN_A_IRQ_OUT = irq_out_r[0];
	assign O_CHAN_A_IRQ_OE_N = irq_oe_n_r[0];
	assign O_CHAN_B_IRQ_OUT = irq_out_r[1];
	assign O_CHAN_B_IRQ_OE_N = irq_oe_n_r[1];
	assign O_CHAN_C_IRQ_OUT = irq_out_r[2];
	assign O_CHAN_C_IRQ_OE_N = irq_oe_n_r[2];
	assign O_CHAN_D_IRQ_OUT = irq_out_r[3];
	assign O_CHAN_D_IRQ_OE_N = irq_oe_n_r[3];
endmodule // qhb_host_bus

// file: verification/qhb_host_bus_props.sv
`timescale 1ns/1ps
module qhb_host_bus_props import qhb_pkg::*; (
	input wire logic I_MCLK,
	input wire logic I_SYS_RST,
	input wire logic I_BUS_MODE,
	input wire logic I_IRQ_DRIVE_OVERRIDE,
	input wire logic [3:0] I_CHAN_IRQ_PEND,
	input wire logic [7:0] I_REG_RDATA,
	input wire logic [7:0] O_DATA,
	input wire logic O_DATA_OE_N,
	input wire logic O_REG_RD,
	input wire logic O_REG_WR,
	input wire logic [1:0] O_REG_CHAN,
	input wire logic [2:0] O_REG_ADDR,
	input wire logic [7:0] O_REG_WDATA,
	input wire logic O_CHAN_A_IRQ_OUT,
	input wire logic O_CHAN_B_IRQ_OUT,
	input wire logic O_CHAN_C_IRQ_OUT,
	input wire logic O_CHAN_D_IRQ_OUT,
	input wire logic O_CHAN_A_IRQ_OE_N,
	input wire logic O_CHAN_B_IRQ_OE_N,
	input wire logic O_CHAN_C_IRQ_OE_N,
	input wire logic O_CHAN_D_IRQ_OE_N
);
	wire [3:0] irq = {O_CHAN_D_IRQ_OUT, O_CHAN_C_IRQ_OUT, O_CHAN_B_IRQ_OUT,
		O_CHAN_A_IRQ_OUT};
	wire [3:0] oe_n = {O_CHAN_D_IRQ_OE_N, O_CHAN_C_IRQ_OE_N,
		O_CHAN_B_IRQ_OE_N, O_CHAN_A_IRQ_OE_N};
	default clocking @(posedge I_MCLK);
	endclocking
	default disable iff (I_SYS_RST);
	// Eight steady cycles cover the pin synchroniser and the output flop.
	sequence line_seen;
		!I_BUS_MODE [*8];
	endsequence
	sequence strobe_sel_lo;
		(I_BUS_MODE && !I_IRQ_DRIVE_OVERRIDE) [*8];
	endsequence
	sequence strobe_sel_hi;
		(I_BUS_MODE && I_IRQ_DRIVE_OVERRIDE) [*8];
	endsequence
	a_rd_pulse_one: assert property (O_REG_RD |=> !O_REG_RD)
		else $error("read pulse too long");
	a_rd_data_out: assert property (O_REG_RD |=> !O_DATA_OE_N &&
		O_DATA == $past(I_REG_RDATA)) else $error("read data wrong");
	a_oe_needs_rd: assert property ($fell(O_DATA_OE_N) |->
		$past(O_REG_RD)) else $error("data driven without read");
	a_wr_pulse_one: assert property (O_REG_WR |=> !O_REG_WR)
		else $error("write pulse too long");
	a_line_irq_a: assert property (line_seen |-> !O_CHAN_A_IRQ_OUT &&
		O_CHAN_A_IRQ_OE_N == !(|$past(I_CHAN_IRQ_PEND)))
		else $error("shared request wrong");
	a_line_bcd_low: assert property (line_seen |->
		irq[3:1] == 3'h0 && oe_n[3:1] == 3'h0) else $error("b to d not low");
	a_strobe_irq_follow: assert property (I_BUS_MODE [*8] |->
		irq == $past(I_CHAN_IRQ_PEND)) else $error("irq not pending");
	a_sel_drives_all: assert property (strobe_sel_hi |->
		oe_n == 4'h0) else $error("override not driving");
	a_mcr_enable_a: assert property (
		strobe_sel_lo ##0 (O_REG_WR && O_REG_CHAN == 2'h0 &&
		O_REG_ADDR == MODEM_CTRL_IDX) |->
		##1 O_CHAN_A_IRQ_OE_N == !O_REG_WDATA[MODEM_CTRL_IRQ_EN_BIT])
		else $error("enable bit ignored");
endmodule // qhb_host_bus_props
bind qhb_host_bus qhb_host_bus_props u_props (.*);

// file: verification/qhb_host_model.sv
`timescale 1ns/1ps
module qhb_host_model (
	input wire logic i_clk,
	output logic o_mode,
	output logic o_sel,
	output logic o_wr_n,
	output logic o_rd_n,
	output logic [3:0] o_cs_n,
	output logic [2:0] o_addr,
	output logic [7:0] o_data
);
	initial begin
		o_mode = 1'b1;
		o_sel = 1'b0;
		o_wr_n = 1'b1;
		o_rd_n = 1'b1;
		o_cs_n = 4'hf;
		o_addr = 3'h0;
		o_data = 8'h00;
	end
	task setup(input logic m, input logic s);
		@(posedge i_clk);
		#2;
		o_mode = m;
		o_sel = m & s;
		repeat (8) @(posedge i_clk);
	endtask
	task acc(input logic rd, input logic [1:0] ch, input logic [2:0] a,
		input logic [7:0] d, input int n);
		@(posedge i_clk);
		#2;
		o_addr = a;
		o_data = d;
		if (o_mode) begin
			o_cs_n = ~(4'h1 << ch);
			o_rd_n = !rd;
			o_wr_n = rd;
		end else begin
			o_cs_n = {1'b1, ch, 1'b0};
			o_wr_n = rd;
		end
		repeat (n) @(posedge i_clk);
		#2;
		o_cs_n = 4'hf;
		o_rd_n = 1'b1;
		if (o_mode) begin
			o_wr_n = 1'b1;
		end
		// Data and direction outlive the strobe so the end edge sees them.
		repeat (4) @(posedge i_clk);
		#2;
		o_wr_n = 1'b1;
		o_data = ~d;
		repeat (4) @(posedge i_clk);
	endtask
endmodule // qhb_host_model

// file: verification/test_qhb_host_bus.sv
`timescale 1ns/1ps
`define CHK(g, x) begin total_checks++; if ((g) !== (x)) begin errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x); end end
module test_qhb_host_bus import qhb_pkg::*;;
	logic I_MCLK = 1'b0;
	logic I_SYS_RST = 1'b1;
	logic [3:0] I_CHAN_IRQ_PEND = 4'h0;
	logic [7:0] I_REG_RDATA = 8'h00;
	wire I_BUS_MODE, I_WRITE_STROBE_N, I_READ_STROBE_N, I_IRQ_DRIVE_OVERRIDE;
	wire I_CHAN_A_SELECT_N, I_CHAN_B_SELECT_N, I_CHAN_C_SELECT_N;
	wire I_CHAN_D_SELECT_N;
	wire [2:0] I_ADDR;
	wire [7:0] I_DATA;
	logic [7:0] O_DATA, O_REG_WDATA;
	logic O_DATA_OE_N, O_REG_RD, O_REG_WR;
	logic [1:0] O_REG_CHAN;
	logic [2:0] O_REG_ADDR;
	logic O_CHAN_A_IRQ_OUT, O_CHAN_B_IRQ_OUT, O_CHAN_C_IRQ_OUT;
	logic O_CHAN_D_IRQ_OUT, O_CHAN_A_IRQ_OE_N, O_CHAN_B_IRQ_OE_N;
	logic O_CHAN_C_IRQ_OE_N, O_CHAN_D_IRQ_OE_N;
	wire [3:0] oe_n = {O_CHAN_D_IRQ_OE_N, O_CHAN_C_IRQ_OE_N,
		O_CHAN_B_IRQ_OE_N, O_CHAN_A_IRQ_OE_N};
	wire [3:0] irq = {O_CHAN_D_IRQ_OUT, O_CHAN_C_IRQ_OUT, O_CHAN_B_IRQ_OUT,
		O_CHAN_A_IRQ_OUT};
	int errors = 0;
	int total_checks = 0;
	logic [13:0] q[$];
	logic [13:0] e;
	logic [13:0] rv;
	logic [13:0] got;
	int rd_req = 0;
	int rd_exp = 0;
	logic oe_q = 1'b1;
	always #12.5 I_MCLK = ~I_MCLK;
	qhb_host_model host (
		.i_clk(I_MCLK),
		.o_mode(I_BUS_MODE),
		.o_sel(I_IRQ_DRIVE_OVERRIDE),
		.o_wr_n(I_WRITE_STROBE_N),
		.o_rd_n(I_READ_STROBE_N),
		.o_cs_n({I_CHAN_D_SELECT_N, I_CHAN_C_SELECT_N, I_CHAN_B_SELECT_N,
			I_CHAN_A_SELECT_N}),
		.o_addr(I_ADDR),
		.o_data(I_DATA)
	);
	qhb_host_bus uut (.*);
	task end_of_test;
		if (errors == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task xfer(input logic rd, input logic [1:0] ch, input logic [2:0] a,
		input logic [7:0] d, input logic [3:0] p);
		#2;
		I_REG_RDATA = d;
		I_CHAN_IRQ_PEND = p;
		rd_exp += rd;
		q.push_back({!rd, ch, a, d});
		host.acc(rd, ch, a, d, 6 + $urandom % 6);
	endtask
	task irqchk(input logic [3:0] eo, input logic [3:0] ei);
		repeat (3) @(posedge I_MCLK);
		#2;
		`CHK({oe_n, irq}, {eo, ei})
		@(posedge I_MCLK);
	endtask
	always @(posedge I_MCLK) begin
		#1;
		if (O_REG_RD) begin
			rd_req++;
		end
		if (O_REG_WR || (oe_q && !O_DATA_OE_N)) begin
			e = q.pop_front();
			got = {O_REG_WR, O_REG_CHAN, O_REG_ADDR,
				O_REG_WR ? O_REG_WDATA : O_DATA};
			`CHK(got, e)
		end
		oe_q = O_DATA_OE_N;
	end
	initial begin
		#60000;
		errors++;
		end_of_test;
	end
	initial begin
		void'($urandom(81538));
		repeat (6) @(posedge I_MCLK);
		#2;
		I_SYS_RST = 0;
		repeat (6) @(posedge I_MCLK);
		#2;
		I_CHAN_IRQ_PEND = 4'($urandom);
		host.setup(MODE_STROBE, 1'b0);
		irqchk(4'hf, I_CHAN_IRQ_PEND);
		xfer(1'b0, 2'h0, MODEM_CTRL_IDX, 8'h08, I_CHAN_IRQ_PEND);
		irqchk(4'he, I_CHAN_IRQ_PEND);
		host.setup(MODE_STROBE, 1'b1);
		irqchk(4'h0, I_CHAN_IRQ_PEND);
		host.setup(MODE_STROBE, 1'b0);
		xfer(1'b0, 2'h0, MODEM_CTRL_IDX, 8'hf7, I_CHAN_IRQ_PEND);
		irqchk(4'hf, I_CHAN_IRQ_PEND);
		for (int m = 0; m < 2; m++) begin
			host.setup(m == 0, 1'b1);
			for (int i = 0; i < 12; i++) begin
				rv = 14'($urandom);
				xfer(rv[13], rv[12:11], rv[10:8], rv[7:0], rv[3:0]);
			end
		end
		#2;
		I_CHAN_IRQ_PEND = 4'h4;
		irqchk(4'h0, 4'h0);
		#2;
		I_CHAN_IRQ_PEND = 4'h0;
		irqchk(4'h1, 4'h0);
		`CHK(q.size(), 0)
		`CHK(rd_req, rd_exp)
		end_of_test;
	end
endmodule // test_qhb_host_bus
